// file: logic/cfg_prot_pkg.sv
// constants and types of the configuration protection and identification block
//
// Behaviour
// (RULE1) config write lock writable only in programming mode
// (RULE2) unimplemented protection bits read back zero
// (RULE3) block1 lock zero blocks foreign table reads
// (RULE4) block0 lock guards block0, range by boot size
// (RULE5) boot lock guards boot block, 2K or 4K
// (RULE6) protection bits erase to one, only clearable
// (RULE7) id low: revision low five, part bits top
// (RULE8) id high: eight upper part identifier bits
// (RULE9) software compares full eleven bit identifier
// (RULE10) id registers read only, writes ignored
// (RULE11) blocked table read returns zero, no fault
package cfg_prot_pkg;

	localparam int ADDR_W = 22;
	localparam int DATA_W = 8;

	// configuration byte addresses
	localparam logic [21:0] ADDR_WRITE_LOCK_HIGH = 22'h30000b;
	localparam logic [21:0] ADDR_TBL_LOCK_LOW = 22'h30000c;
	localparam logic [21:0] ADDR_TBL_LOCK_HIGH = 22'h30000d;
	// identification bytes carry no printed offset here
	localparam logic [21:0] ADDR_PART_ID_LOW = 22'h3ffffe;
	localparam logic [21:0] ADDR_PART_ID_HIGH = 22'h3fffff;

	// field positions
	localparam int BIT_BOOT_WR_LOCK = 6;
	localparam int BIT_CFG_WR_LOCK = 5;
	localparam int BIT_BLK1_TBL_LOCK = 1;
	localparam int BIT_BLK0_TBL_LOCK = 0;
	localparam int BIT_BOOT_TBL_LOCK = 6;

	// implemented-bit masks
	localparam logic [7:0] MASK_WRITE_LOCK_HIGH = 8'h60;
	localparam logic [7:0] MASK_TBL_LOCK_LOW = 8'h03;
	localparam logic [7:0] MASK_TBL_LOCK_HIGH = 8'h40;

	// unprogrammed value of every protection bit
	localparam logic [7:0] ERASED = 8'hff;

	// program memory map
	localparam logic [21:0] BOOT_END_SMALL = 22'h0007ff;
	localparam logic [21:0] BOOT_END_LARGE = 22'h000fff;
	localparam logic [21:0] BLK0_END = 22'h001fff;
	localparam logic [21:0] BLK1_END = 22'h003fff;

	// identification values, arbitrary neutral defaults
	localparam logic [2:0] PART_ID_LOW_BITS = 3'h5;
	localparam logic [7:0] PART_ID_HIGH_BITS = 8'h5a;
	localparam logic [4:0] SILICON_REVISION = 5'h03;

	typedef enum logic [1:0] {
		REGION_BOOT,
		REGION_BLK0,
		REGION_BLK1,
		REGION_OTHER
	} region_e;

endpackage : cfg_prot_pkg

// file: logic/region_decode.sv
// maps a program memory address to its protection region
module region_decode (
	// address and boot size
	input wire logic [21:0] addr_i,
	input wire logic boot_large_i,
	// region
	output cfg_prot_pkg::region_e region_o
);

	logic [21:0] boot_end;

	// boot block ends at 2K or 4K; block 0 starts right after it [RULE4] [RULE5]
	always_comb begin
		boot_end = boot_large_i ? cfg_prot_pkg::BOOT_END_LARGE : cfg_prot_pkg::BOOT_END_SMALL;
		if (addr_i <= boot_end) begin
			region_o = cfg_prot_pkg::REGION_BOOT;
		end else if (addr_i <= cfg_prot_pkg::BLK0_END) begin
			region_o = cfg_prot_pkg::REGION_BLK0;
		end else if (addr_i <= cfg_prot_pkg::BLK1_END) begin
			region_o = cfg_prot_pkg::REGION_BLK1;
		end else begin
			region_o = cfg_prot_pkg::REGION_OTHER;
		end
	end

endmodule // region_decode

// file: logic/id_rom.sv
// read-only identification bytes with registered read data
module id_rom (
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_b_i,
	// read port
	input wire logic sel_high_i,
	output logic [7:0] data_o
);

	typedef struct packed {
		logic [7:0] data;
	} state_s;

	state_s state;
	state_s next_state;

	// no write path exists at all, so the contents cannot change [RULE10]
	always_comb begin
		next_state = state;
		if (sel_high_i) begin
			next_state.data = cfg_prot_pkg::PART_ID_HIGH_BITS; // [RULE8]
		end else begin
			next_state.data = {cfg_prot_pkg::PART_ID_LOW_BITS,
				cfg_prot_pkg::SILICON_REVISION}; // [RULE7]
		end
	end

	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	assign data_o = state.data;

endmodule // id_rom

// file: logic/config_protect_and_id_regs.sv
// protection configuration bytes, identification bytes and table read gate
module config_protect_and_id_regs (
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_b_i,
	// mode pins from outside the clock domain
	input wire logic prog_mode_i,
	input wire logic boot_large_i,
	// register port
	input wire logic [21:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [7:0] reg_rdata_o,
	// table read request from the core
	input wire logic tbl_rd_i,
	input wire logic [21:0] tbl_addr_i,
	input wire logic [21:0] exec_addr_i,
	// program memory read data for the table read address
	input wire logic [7:0] mem_rdata_i,
	// table read answer
	output logic tbl_valid_o,
	output logic tbl_blocked_o,
	output logic [7:0] tbl_rdata_o,
	// lock levels to the write protection logic
	output logic boot_block_write_lock_o,
	output logic config_area_write_lock_o
);

	////////////////////////////////////////////////////////////////////////
	// state

	typedef struct packed {
		logic [1:0] prog_sync;
		logic [1:0] boot_sync;
		logic boot_block_write_lock;
		logic config_area_write_lock;
		logic block1_table_read_lock;
		logic block0_table_read_lock;
		logic boot_block_table_read_lock;
		logic [7:0] rdata;
		logic id_read;
		logic tbl_valid;
		logic tbl_blocked;
		logic [7:0] tbl_rdata;
	} state_s;

	state_s state;
	state_s next_state;

	logic prog_mode;
	logic boot_large;
	logic [7:0] id_data;
	logic id_sel_high;
	cfg_prot_pkg::region_e tgt_region;
	cfg_prot_pkg::region_e src_region;
	logic tbl_lock_hit;

	assign prog_mode = state.prog_sync[1];
	assign boot_large = state.boot_sync[1];
	assign id_sel_high = (reg_addr_i == cfg_prot_pkg::ADDR_PART_ID_HIGH);

	////////////////////////////////////////////////////////////////////////
	// submodules

	id_rom u_id_rom (
		.ref_clk_i(ref_clk_i),
		.rst_b_i(rst_b_i),
		.sel_high_i(id_sel_high),
		.data_o(id_data)
	);

	region_decode u_tgt_decode (
		.addr_i(tbl_addr_i),
		.boot_large_i(boot_large),
		.region_o(tgt_region)
	);

	region_decode u_src_decode (
		.addr_i(exec_addr_i),
		.boot_large_i(boot_large),
		.region_o(src_region)
	);

	////////////////////////////////////////////////////////////////////////
	// table read gate: a read from inside the same block is always allowed

	always_comb begin
		tbl_lock_hit = 1'b0;
		if (tgt_region != src_region) begin
			unique case (tgt_region)
				cfg_prot_pkg::REGION_BOOT: begin
					tbl_lock_hit = !state.boot_block_table_read_lock; // [RULE5]
				end
				cfg_prot_pkg::REGION_BLK0: begin
					tbl_lock_hit = !state.block0_table_read_lock; // [RULE4]
				end
				cfg_prot_pkg::REGION_BLK1: begin
					tbl_lock_hit = !state.block1_table_read_lock; // [RULE3]
				end
				cfg_prot_pkg::REGION_OTHER: begin
					tbl_lock_hit = 1'b0;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		next_state = state;
		next_state.prog_sync = {state.prog_sync[0], prog_mode_i};
		next_state.boot_sync = {state.boot_sync[0], boot_large_i};

		// writes can only clear a bit: new = old and data [RULE6]
		if (reg_wr_i) begin
			unique case (reg_addr_i)
				cfg_prot_pkg::ADDR_WRITE_LOCK_HIGH: begin
					next_state.boot_block_write_lock = state.boot_block_write_lock
						& reg_wdata_i[cfg_prot_pkg::BIT_BOOT_WR_LOCK]; // [RULE6]
					if (prog_mode) begin
						next_state.config_area_write_lock = state.config_area_write_lock
							& reg_wdata_i[cfg_prot_pkg::BIT_CFG_WR_LOCK]; // [RULE1]
					end
				end
				cfg_prot_pkg::ADDR_TBL_LOCK_LOW: begin
					next_state.block1_table_read_lock = state.block1_table_read_lock
						& reg_wdata_i[cfg_prot_pkg::BIT_BLK1_TBL_LOCK]; // [RULE6]
					next_state.block0_table_read_lock = state.block0_table_read_lock
						& reg_wdata_i[cfg_prot_pkg::BIT_BLK0_TBL_LOCK]; // [RULE6]
				end
				cfg_prot_pkg::ADDR_TBL_LOCK_HIGH: begin
					next_state.boot_block_table_read_lock = state.boot_block_table_read_lock
						& reg_wdata_i[cfg_prot_pkg::BIT_BOOT_TBL_LOCK]; // [RULE6]
				end
				default: begin
					// identification and unmapped addresses ignore writes [RULE10]
				end
			endcase
		end

		// read data, unmapped and unimplemented bits read zero [RULE2]
		next_state.id_read = 1'b0;
		next_state.rdata = 8'h00;
		if (reg_rd_i) begin
			unique case (reg_addr_i)
				cfg_prot_pkg::ADDR_WRITE_LOCK_HIGH: begin
					next_state.rdata[cfg_prot_pkg::BIT_BOOT_WR_LOCK] = state.boot_block_write_lock;
					next_state.rdata[cfg_prot_pkg::BIT_CFG_WR_LOCK] =
						state.config_area_write_lock;
				end
				cfg_prot_pkg::ADDR_TBL_LOCK_LOW: begin
					next_state.rdata[cfg_prot_pkg::BIT_BLK1_TBL_LOCK] =
						state.block1_table_read_lock;
					next_state.rdata[cfg_prot_pkg::BIT_BLK0_TBL_LOCK] =
						state.block0_table_read_lock;
				end
				cfg_prot_pkg::ADDR_TBL_LOCK_HIGH: begin
					next_state.rdata[cfg_prot_pkg::BIT_BOOT_TBL_LOCK] =
						state.boot_block_table_read_lock;
				end
				cfg_prot_pkg::ADDR_PART_ID_LOW, cfg_prot_pkg::ADDR_PART_ID_HIGH: begin
					next_state.id_read = 1'b1; // [RULE7] [RULE8]
				end
				default: begin
					next_state.rdata = 8'h00;
				end
			endcase
		end

		// a blocked read completes normally with zero data [RULE11]
		next_state.tbl_valid = tbl_rd_i;
		next_state.tbl_blocked = tbl_rd_i & tbl_lock_hit;
		next_state.tbl_rdata = (tbl_rd_i && !tbl_lock_hit) ? mem_rdata_i : 8'h00; // [RULE11]
	end

	////////////////////////////////////////////////////////////////////////
	// registers; locks stand in the erased state after reset

	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			state <= '0;
			state.boot_block_write_lock <= 1'b1; // [RULE6]
			state.config_area_write_lock <= 1'b1; // [RULE6]
			state.block1_table_read_lock <= 1'b1; // [RULE6]
			state.block0_table_read_lock <= 1'b1; // [RULE6]
			state.boot_block_table_read_lock <= 1'b1; // [RULE6]
		end else begin
			state <= next_state;
		end
	end

	// id bytes come registered from their own rom, aligned with rdata
	assign reg_rdata_o = state.id_read ? id_data : state.rdata;
	assign tbl_valid_o = state.tbl_valid;
	assign tbl_blocked_o = state.tbl_blocked;
	assign tbl_rdata_o = state.tbl_rdata;
	assign boot_block_write_lock_o = state.boot_block_write_lock;
	assign config_area_write_lock_o = state.config_area_write_lock;

endmodule // config_protect_and_id_regs

// file: test/cfg_prot_checker.sv
// port assertions for the protection and identification block
module cfg_prot_checker (
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_b_i,
	// inputs
	input wire logic prog_mode_i,
	input wire logic boot_large_i,
	input wire logic [21:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic tbl_rd_i,
	input wire logic [21:0] tbl_addr_i,
	input wire logic [21:0] exec_addr_i,
	input wire logic [7:0] mem_rdata_i,
	// outputs
	input wire logic [7:0] reg_rdata_o,
	input wire logic tbl_valid_o,
	input wire logic tbl_blocked_o,
	input wire logic [7:0] tbl_rdata_o,
	input wire logic boot_block_write_lock_o,
	input wire logic config_area_write_lock_o
);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!rst_b_i);
	////////////////////////////////////////////////////////////////////////////////
	property p_tbl_ans; tbl_rd_i |=> tbl_valid_o; endproperty
	a_tbl_ans: assert property (p_tbl_ans)
		else $error("table read not answered");
	property p_blk_zero; tbl_blocked_o |-> tbl_valid_o && tbl_rdata_o == 8'h00; endproperty
	a_blk_zero: assert property (p_blk_zero)
		else $error("blocked read leaked data");
	property p_pass; tbl_valid_o && !tbl_blocked_o |-> tbl_rdata_o == $past(mem_rdata_i); endproperty
	a_pass: assert property (p_pass)
		else $error("permitted read data wrong");
	property p_hi_free; tbl_rd_i && tbl_addr_i > cfg_prot_pkg::BLK1_END |=> !tbl_blocked_o; endproperty
	a_hi_free: assert property (p_hi_free)
		else $error("unguarded area blocked");
	property p_low_unimp;
		reg_rd_i && reg_addr_i == cfg_prot_pkg::ADDR_TBL_LOCK_LOW |=> reg_rdata_o[7:2] == 6'h00;
	endproperty
	a_low_unimp: assert property (p_low_unimp)
		else $error("low lock byte upper bits set");
	property p_high_unimp;
		reg_rd_i && reg_addr_i == cfg_prot_pkg::ADDR_TBL_LOCK_HIGH |=> (reg_rdata_o & 8'hbf) == 8'h00;
	endproperty
	a_high_unimp: assert property (p_high_unimp)
		else $error("high lock byte spare bits set");
	property p_id_low;
		reg_rd_i && reg_addr_i == cfg_prot_pkg::ADDR_PART_ID_LOW
			|=> reg_rdata_o == {cfg_prot_pkg::PART_ID_LOW_BITS, cfg_prot_pkg::SILICON_REVISION};
	endproperty
	a_id_low: assert property (p_id_low)
		else $error("id low byte wrong");
	property p_id_high;
		reg_rd_i && reg_addr_i == cfg_prot_pkg::ADDR_PART_ID_HIGH
			|=> reg_rdata_o == cfg_prot_pkg::PART_ID_HIGH_BITS;
	endproperty
	a_id_high: assert property (p_id_high)
		else $error("id high byte wrong");
	// mode pin passes two sync flops, so look three and four edges back
	property p_cfg_prog;
		$fell(config_area_write_lock_o) |-> $past(prog_mode_i, 3) || $past(prog_mode_i, 4);
	endproperty
	a_cfg_prog: assert property (p_cfg_prog)
		else $error("config lock cleared outside programming mode");
	property p_no_rise; !$rose(boot_block_write_lock_o) && !$rose(config_area_write_lock_o); endproperty
	a_no_rise: assert property (p_no_rise)
		else $error("lock bit set again");
	cover property (tbl_blocked_o);
	cover property ($fell(config_area_write_lock_o));
	cover property ($fell(boot_block_write_lock_o));
endmodule // cfg_prot_checker

// file: test/tb_top.sv
// self-checking bench for the protection and identification block
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin fail_count++; \
	$display("[ERR] %0t got %h want %h", $time, a, e); end end
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic ref_clk_i, rst_b_i, prog_mode_i, boot_large_i, reg_wr_i, reg_rd_i, tbl_rd_i;
	logic tbl_valid_o, tbl_blocked_o, boot_block_write_lock_o, config_area_write_lock_o;
	logic [21:0] reg_addr_i, tbl_addr_i, exec_addr_i;
	logic [7:0] reg_wdata_i, mem_rdata_i, reg_rdata_o, tbl_rdata_o, q;
	logic [9:0] t;
	logic [10:0] pid;
	int fail_count, tests_run;
	config_protect_and_id_regs dut_u (.ref_clk_i, .rst_b_i, .prog_mode_i, .boot_large_i,
		.reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .tbl_rd_i, .tbl_addr_i,
		.exec_addr_i, .mem_rdata_i, .tbl_valid_o, .tbl_blocked_o, .tbl_rdata_o,
		.boot_block_write_lock_o, .config_area_write_lock_o);
	initial begin
		ref_clk_i = 1'b0;
		forever #4 ref_clk_i = ~ref_clk_i;
	end
	////////////////////////////////////////////////////////////////////////////////
	task automatic wr(input logic [21:0] a, input logic [7:0] d);
		@(posedge ref_clk_i);
		reg_wr_i <= 1'b1;
		reg_addr_i <= a;
		reg_wdata_i <= d;
		@(posedge ref_clk_i);
		reg_wr_i <= 1'b0;
	endtask
	task automatic rd(input logic [21:0] a);
		@(posedge ref_clk_i);
		reg_rd_i <= 1'b1;
		reg_addr_i <= a;
		@(posedge ref_clk_i);
		reg_rd_i <= 1'b0;
		#1 q = reg_rdata_o;
	endtask
	// answer stands one cycle only, so it is sampled just after the taking edge
	task automatic tr(input logic [21:0] a, input logic [21:0] e, input logic [7:0] m);
		@(posedge ref_clk_i);
		tbl_rd_i <= 1'b1;
		tbl_addr_i <= a;
		exec_addr_i <= e;
		mem_rdata_i <= m;
		@(posedge ref_clk_i);
		tbl_rd_i <= 1'b0;
		#1 t = {tbl_valid_o, tbl_blocked_o, tbl_rdata_o};
	endtask
	////////////////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		rd(cfg_prot_pkg::ADDR_WRITE_LOCK_HIGH);
		`CHK(q, 8'h60)
		rd(cfg_prot_pkg::ADDR_TBL_LOCK_LOW);
		`CHK(q, 8'h03)
		rd(cfg_prot_pkg::ADDR_TBL_LOCK_HIGH);
		`CHK(q, 8'h40)
		`CHK({boot_block_write_lock_o, config_area_write_lock_o}, 2'h3)
		$display("t_reset done");
	endtask
	task automatic t_id_ro();
		wr(cfg_prot_pkg::ADDR_PART_ID_LOW, 8'h00);
		wr(cfg_prot_pkg::ADDR_PART_ID_HIGH, 8'h00);
		rd(cfg_prot_pkg::ADDR_PART_ID_LOW);
		`CHK(q, {cfg_prot_pkg::PART_ID_LOW_BITS, cfg_prot_pkg::SILICON_REVISION})
		pid[2:0] = q[7:5];
		rd(cfg_prot_pkg::ADDR_PART_ID_HIGH);
		`CHK(q, cfg_prot_pkg::PART_ID_HIGH_BITS)
		pid[10:3] = q;
		// the high byte alone may be shared, so the part is told by all eleven bits
		`CHK(pid, {cfg_prot_pkg::PART_ID_HIGH_BITS, cfg_prot_pkg::PART_ID_LOW_BITS})
		$display("t_id_ro done");
	endtask
	task automatic t_cfg();
		wr(cfg_prot_pkg::ADDR_WRITE_LOCK_HIGH, 8'h00);
		rd(cfg_prot_pkg::ADDR_WRITE_LOCK_HIGH);
		`CHK(q, 8'h20)
		wr(cfg_prot_pkg::ADDR_WRITE_LOCK_HIGH, 8'hff);
		rd(cfg_prot_pkg::ADDR_WRITE_LOCK_HIGH);
		`CHK(q, 8'h20)
		@(posedge ref_clk_i);
		prog_mode_i <= 1'b1;
		repeat (3) @(posedge ref_clk_i);
		wr(cfg_prot_pkg::ADDR_WRITE_LOCK_HIGH, 8'h00);
		rd(cfg_prot_pkg::ADDR_WRITE_LOCK_HIGH);
		`CHK(q, 8'h00)
		`CHK(config_area_write_lock_o, 1'b0)
		@(posedge ref_clk_i);
		prog_mode_i <= 1'b0;
		$display("t_cfg done");
	endtask
	task automatic t_tbl();
		tr(22'h002100, 22'h000100, 8'ha5);
		`CHK(t, 10'h2a5)
		wr(cfg_prot_pkg::ADDR_TBL_LOCK_LOW, 8'h01);
		tr(22'h002100, 22'h000100, 8'ha5);
		`CHK(t, 10'h300)
		tr(22'h002100, 22'h003000, 8'h3c);
		`CHK(t, 10'h23c)
		tr(22'h004000, 22'h000100, 8'h77);
		`CHK(t, 10'h277)
		wr(cfg_prot_pkg::ADDR_TBL_LOCK_LOW, 8'h00);
		tr(22'h000900, 22'h002100, 8'h11);
		`CHK(t, 10'h300)
		@(posedge ref_clk_i);
		boot_large_i <= 1'b1;
		repeat (3) @(posedge ref_clk_i);
		tr(22'h000900, 22'h002100, 8'h22);
		`CHK(t, 10'h222)
		tr(22'h001000, 22'h002100, 8'h23);
		`CHK(t, 10'h300)
		wr(cfg_prot_pkg::ADDR_TBL_LOCK_HIGH, 8'h00);
		tr(22'h000900, 22'h002100, 8'h33);
		`CHK(t, 10'h300)
		tr(22'h000900, 22'h000100, 8'h44);
		`CHK(t, 10'h244)
		rd(cfg_prot_pkg::ADDR_TBL_LOCK_HIGH);
		`CHK(q, 8'h00)
		$display("t_tbl done");
	endtask
	// mid-run reset: every lock cleared above must come back erased
	task automatic t_rst();
		@(posedge ref_clk_i);
		rst_b_i <= 1'b0;
		repeat (2) @(posedge ref_clk_i);
		rst_b_i <= 1'b1;
		#1;
		`CHK({boot_block_write_lock_o, config_area_write_lock_o}, 2'h3)
		rd(cfg_prot_pkg::ADDR_WRITE_LOCK_HIGH);
		`CHK(q, 8'h60)
		rd(cfg_prot_pkg::ADDR_TBL_LOCK_LOW);
		`CHK(q, 8'h03)
		rd(cfg_prot_pkg::ADDR_TBL_LOCK_HIGH);
		`CHK(q, 8'h40)
		$display("t_rst done");
	endtask
	task automatic give_verdict();
		$display("tests_run %0d fail_count %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		{rst_b_i, prog_mode_i, boot_large_i, reg_wr_i, reg_rd_i, tbl_rd_i} = 6'h00;
		{reg_addr_i, tbl_addr_i, exec_addr_i, reg_wdata_i, mem_rdata_i} = 82'h0;
		repeat (6) @(posedge ref_clk_i);
		rst_b_i <= 1'b1;
		t_reset();
		t_id_ro();
		t_cfg();
		t_tbl();
		t_rst();
		give_verdict();
	end
	initial begin
		repeat (5000) @(posedge ref_clk_i);
		fail_count++;
		give_verdict();
	end
endmodule // tb_top
bind config_protect_and_id_regs cfg_prot_checker chk_u (.ref_clk_i, .rst_b_i, .prog_mode_i,
	.boot_large_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .tbl_rd_i, .tbl_addr_i,
	.exec_addr_i, .mem_rdata_i, .reg_rdata_o, .tbl_valid_o, .tbl_blocked_o, .tbl_rdata_o,
	.boot_block_write_lock_o, .config_area_write_lock_o);
